// ===== rtl/rip_pkg.sv
// package: constants, register map and states for the reset and interrupt block
package rip_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_ENABLE = 8'h00;   // [15:4] per source enables, [0] master
  localparam logic [7:0] OFF_LATCH = 8'h04;    // [15:2] pending latches, write 0 clears
  localparam logic [7:0] OFF_CTRL = 8'h08;     // trap/wdog select, pin irq enable, selectors
  localparam logic [7:0] OFF_SYSCTL = 8'h0c;   // [7] hf enable, [6] lf enable, [5] sysclk sel
  localparam logic [7:0] OFF_STATUS = 8'h10;   // reset cause, accepted vector
  // control field positions
  localparam int CTRL_RAM_TRAP = 0;
  localparam int CTRL_TRAP_OUT = 1;
  localparam int CTRL_WDOG_OUT = 2;
  localparam int CTRL_PIN0_EN = 3;
  localparam int CTRL_SEL14 = 4;
  localparam int CTRL_SEL15 = 5;
  localparam int SYS_HF_EN = 7;
  localparam int SYS_LF_EN = 6;
  localparam int SYS_CLK_SEL = 5;
  // reset values
  localparam logic [5:0] CTRL_RESET = 6'h06;
  localparam logic [7:0] SYSCTL_RESET = 8'hc0;
  // timing: clock 100 MHz, period 10 ns
  localparam int CLK_NS = 10;
  localparam int FC_NS = 10;                   // fc taken as the core clock
  localparam int MALF_FC_PERIODS = 24;         // malfunction reset span in fc periods
  localparam int MALF_CYCLES = (MALF_FC_PERIODS * FC_NS) / CLK_NS;
  localparam int EXT_FC_PERIODS = 12;          // least pin low time in fc periods
  localparam int EXT_CYCLES = (EXT_FC_PERIODS * FC_NS + CLK_NS - 1) / CLK_NS;
  // vectors
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_SOFT = 16'hfffc;
  localparam logic [15:0] VEC_LAT2 = 16'hfffa;
  localparam int NUM_LAT = 16;
  typedef enum logic [2:0] {
    RIP_IDLE = 3'b001,
    RIP_MALF = 3'b010,
    RIP_EXT = 3'b100
  } rip_rst_e;
endpackage : rip_pkg

// ===== rtl/rip_ack_if.sv
// interface: accept request and answer between arbiter and latch bank
`timescale 1ns/1ps
`default_nettype none
interface rip_ack_if;
  logic [15:0] lat;
  logic [15:0] maskok;
  logic take;
  logic [3:0] idx;
  modport bank (output lat, input maskok, input take, input idx);
  modport arb (input lat, output maskok, output take, output idx);
endinterface : rip_ack_if
`default_nettype wire

// ===== rtl/rip_latch_bank.sv
// module: interrupt pending latches with hardware set and software clear
`timescale 1ns/1ps
`default_nettype none
module rip_latch_bank (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] req,
  input wire logic sw_clr,
  input wire logic [15:0] sw_mask,
  rip_ack_if.bank ack
);
  logic [15:0] lat;
  logic [15:0] next_lat;
  logic [15:0] kill;

  // clear by write or by acceptance, then set; set wins
  always_comb
  begin
    kill = sw_clr ? ~sw_mask : 16'h0000;
    if (ack.take)
      kill[ack.idx] = 1'b1;
    next_lat = (lat & ~kill) | req;
    next_lat[1:0] = 2'b00;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      lat <= 16'h0000;
    else
      lat <= next_lat;
  end
  assign ack.lat = lat;
endmodule : rip_latch_bank
`default_nettype wire

// ===== rtl/rip_core.sv
// module: reset sources, reset stretch and interrupt priority with apb registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - malfunction reset holds internal reset and pin low at most 24 fc
// - malfunction stretch counter not cleared by reset, may fire at power-up
// - reset clears master enable, per source enables and latches
// - reset zeroes prescaler, keeps watchdog enabled; cpu state left alone
// - on pin release, reset ends and program counter loads from top vector
// - fetch from control area, or ram when selected, raises trap event
// - trap event resets while select is one, else non-maskable trap irq
// - watchdog overflow resets while select is one, else watchdog irq
// - bad oscillator enable clearing issues system clock reset
// - eighteen sources, two shared levels, four non-maskable
// - each source request sets its latch, which asks acceptance; soft and bad opcode have no latch here and go straight to fffc
// - maskable accepted only with master and own enable set
// - fixed priority: non-maskable first, then levels four to fifteen
// - no ranking among non-maskable sources themselves; code ranks soft/bad opcode, then trap, then watchdog
// - vectors: soft/bad opcode fffc, trap fffa, wdog fff8, down to ffe0
// - pin irq zero also needs its own pin enable bit
// - levels 14 and 15 pick pin or internal source by selector
// - latch clears as soon as its interrupt is accepted
// - acceptance saves master enable then clears it; return restores; code only clears it and restores from the saved_enable input
// - software writes never set a latch
module rip_core #(
  parameter int MALF_LEN = rip_pkg::MALF_CYCLES,
  parameter int EXT_LEN = rip_pkg::EXT_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic core_reset,
  output logic prescaler_clear,
  output logic wdog_enable,
  input wire logic fetch_valid,
  input wire logic fetch_in_sfr,
  input wire logic fetch_in_ram,
  input wire logic wdog_overflow,
  input wire logic soft_irq,
  input wire logic bad_opcode_irq,
  input wire logic [11:0] ext_req,
  input wire logic uart_tx_irq,
  input wire logic converter_irq,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic saved_enable,
  output logic irq_pending,
  output logic [15:0] irq_vector,
  output logic [15:0] program_counter
);
  rip_ack_if ack ();
  logic [15:0] per_source_irq_enable;
  logic master_irq_enable;
  logic [5:0] ctrl;
  logic [7:0] system_control_two;
  logic [15:0] next_en;
  logic next_master;
  logic [5:0] next_ctrl;
  logic [7:0] next_sys;
  logic [15:0] req;
  logic malf_req;
  logic trap_ev;
  logic sysclk_fault;
  logic apb_wr;
  logic apb_rd_hit;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_slverr;
  rip_pkg::rip_rst_e rst_st;
  rip_pkg::rip_rst_e next_rst_st;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] ext_cnt;
  logic [7:0] next_ext_cnt;
  logic [1:0] cause;
  logic [1:0] next_cause;
  logic [15:0] next_vec;
  logic next_pend;
  logic [15:0] next_pc;
  logic next_core_reset;

  // vector of a latch index, levels descend by two
  function automatic logic [15:0] vec_of(input logic [3:0] i);
    vec_of = 16'(rip_pkg::VEC_LAT2 - 16'({12'h000, i - 4'h2} << 1));
  endfunction : vec_of

  // write lands at the edge where the master samples pready high
  assign apb_wr = psel && penable && pwrite && pready;

  assign trap_ev = fetch_valid && (fetch_in_sfr ||
                   (fetch_in_ram && ctrl[rip_pkg::CTRL_RAM_TRAP]));

  always_comb
  begin
    sysclk_fault = 1'b0;
    if (apb_wr && paddr == rip_pkg::OFF_SYSCTL)
    begin
      if (!pwdata[rip_pkg::SYS_HF_EN] && !pwdata[rip_pkg::SYS_LF_EN] &&
          system_control_two[rip_pkg::SYS_HF_EN] && system_control_two[rip_pkg::SYS_LF_EN])
        sysclk_fault = 1'b1;
      if (!pwdata[rip_pkg::SYS_HF_EN] && system_control_two[rip_pkg::SYS_HF_EN] &&
          !system_control_two[rip_pkg::SYS_CLK_SEL])
        sysclk_fault = 1'b1;
      if (!pwdata[rip_pkg::SYS_LF_EN] && system_control_two[rip_pkg::SYS_LF_EN] &&
          system_control_two[rip_pkg::SYS_CLK_SEL])
        sysclk_fault = 1'b1;
    end
  end

  // route trap and watchdog to reset or latch
  always_comb
  begin
    malf_req = sysclk_fault ||
               (trap_ev && ctrl[rip_pkg::CTRL_TRAP_OUT]) ||
               (wdog_overflow && ctrl[rip_pkg::CTRL_WDOG_OUT]);
    req = 16'h0000;
    req[2] = trap_ev && !ctrl[rip_pkg::CTRL_TRAP_OUT];
    req[3] = wdog_overflow && !ctrl[rip_pkg::CTRL_WDOG_OUT];
    req[13:4] = ext_req[9:0];
    req[14] = ctrl[rip_pkg::CTRL_SEL14] ? uart_tx_irq : ext_req[10];
    req[15] = ctrl[rip_pkg::CTRL_SEL15] ? converter_irq : ext_req[11];
  end

  // reset sequencer state
  always_comb
  begin
    next_rst_st = rst_st;
    next_cnt = cnt;
    next_cause = cause;
    next_ext_cnt = reset_pin_in ? 8'h00 : (ext_cnt == 8'hff ? ext_cnt : ext_cnt + 8'h01);
    next_core_reset = core_reset;
    unique case (rst_st)
      rip_pkg::RIP_IDLE:
      begin
        next_core_reset = 1'b0;
        if (malf_req)
        begin
          next_rst_st = rip_pkg::RIP_MALF;
          next_cnt = 8'(MALF_LEN - 1);
          next_core_reset = 1'b1;
          next_cause = 2'h1;
        end
        else if (!reset_pin_in && ext_cnt >= 8'(EXT_LEN - 1))
        begin
          next_rst_st = rip_pkg::RIP_EXT;
          next_core_reset = 1'b1;
          next_cause = 2'h2;
        end
      end
      rip_pkg::RIP_MALF:
      begin
        if (cnt == 8'h00)
        begin
          next_rst_st = rip_pkg::RIP_IDLE;
          next_core_reset = 1'b0;
        end
        else
          next_cnt = cnt - 8'h01;
      end
      rip_pkg::RIP_EXT:
      begin
        if (reset_pin_in)
        begin
          next_rst_st = rip_pkg::RIP_IDLE;
          next_core_reset = 1'b0;
        end
      end
      default:
      begin
        next_rst_st = rip_pkg::RIP_IDLE;
        next_core_reset = 1'b0;
      end
    endcase
  end

  // stretch logic ignores nrst, power-up state may run once
  always_ff @(posedge core_clk)
  begin
    rst_st <= next_rst_st;
    cnt <= next_cnt;
    core_reset <= next_core_reset;
    reset_pin_out <= 1'b0;
    reset_pin_oe <= next_rst_st == rip_pkg::RIP_MALF;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ext_cnt <= 8'h00;
      cause <= 2'h0;
    end
    else
    begin
      ext_cnt <= next_ext_cnt;
      cause <= next_cause;
    end
  end

  // priority resolve and acceptance
  always_comb
  begin
    ack.maskok = 16'h0000;
    ack.take = 1'b0;
    ack.idx = 4'h0;
    next_vec = irq_vector;
    next_pend = 1'b0;
    for (int i = 4; i < rip_pkg::NUM_LAT; i++)
      ack.maskok[i] = ack.lat[i] && master_irq_enable && per_source_irq_enable[i];
    ack.maskok[4] = ack.maskok[4] && ctrl[rip_pkg::CTRL_PIN0_EN];
    for (int i = rip_pkg::NUM_LAT - 1; i >= 4; i--)
      if (ack.maskok[i])
      begin
        ack.idx = 4'(i);
        next_pend = 1'b1;
      end
    // non-maskable set; encoding ranks soft first, then trap over watchdog
    if (ack.lat[3])
    begin
      ack.idx = 4'h3;
      next_pend = 1'b1;
    end
    if (ack.lat[2])
    begin
      ack.idx = 4'h2;
      next_pend = 1'b1;
    end
    if (soft_irq || bad_opcode_irq)
    begin
      next_vec = rip_pkg::VEC_SOFT;
      next_pend = 1'b1;
    end
    else if (next_pend)
      next_vec = vec_of(ack.idx);
    ack.take = irq_ack && next_pend && !(soft_irq || bad_opcode_irq) && !core_reset;
  end

  // latches indexed 2..15, software only clears
  rip_latch_bank u_bank (
    .core_clk(core_clk),
    .nrst(nrst && !core_reset),
    .req(req),
    .sw_clr(apb_wr && paddr == rip_pkg::OFF_LATCH),
    .sw_mask(pwdata[15:0]),
    .ack(ack)
  );

  // register writes and master enable clear and restore
  always_comb
  begin
    next_en = per_source_irq_enable;
    next_master = master_irq_enable;
    next_ctrl = ctrl;
    next_sys = system_control_two;
    if (apb_wr && paddr == rip_pkg::OFF_ENABLE)
    begin
      next_en = {pwdata[15:4], 4'h0};
      next_master = pwdata[0];
    end
    if (apb_wr && paddr == rip_pkg::OFF_CTRL)
      next_ctrl = pwdata[5:0];
    if (apb_wr && paddr == rip_pkg::OFF_SYSCTL)
      next_sys = {pwdata[7:5], 5'h00};
    // clear on accept, restore on return
    if (irq_ack && next_pend)
      next_master = 1'b0;
    else if (irq_return)
      next_master = saved_enable;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || core_reset)
    begin
      per_source_irq_enable <= 16'h0000;
      master_irq_enable <= 1'b0;
      ctrl <= rip_pkg::CTRL_RESET;
      system_control_two <= rip_pkg::SYSCTL_RESET;
      prescaler_clear <= 1'b1;
      wdog_enable <= 1'b1;
      program_counter <= rip_pkg::VEC_RESET;
    end
    else
    begin
      per_source_irq_enable <= next_en;
      master_irq_enable <= next_master;
      ctrl <= next_ctrl;
      system_control_two <= next_sys;
      prescaler_clear <= 1'b0;
      wdog_enable <= wdog_enable;
      program_counter <= next_pc;
    end
  end

  // program counter load from vector on accept
  assign next_pc = (irq_ack && next_pend) ? next_vec : program_counter;

  // apb read mux and one wait state answer
  always_comb
  begin
    apb_rd_hit = 1'b1;
    unique case (paddr)
      rip_pkg::OFF_ENABLE: next_prdata = {16'h0000, per_source_irq_enable[15:4], 3'h0,
                                           master_irq_enable};
      rip_pkg::OFF_LATCH: next_prdata = {16'h0000, ack.lat};
      rip_pkg::OFF_CTRL: next_prdata = {26'h0, ctrl};
      rip_pkg::OFF_SYSCTL: next_prdata = {24'h0, system_control_two};
      rip_pkg::OFF_STATUS: next_prdata = {irq_vector, 14'h0, cause};
      default:
      begin
        next_prdata = 32'h0;
        apb_rd_hit = 1'b0;
      end
    endcase
    next_pready = psel && penable && !pready;
    next_slverr = next_pready && !apb_rd_hit;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_pending <= 1'b0;
      irq_vector <= rip_pkg::VEC_RESET;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_slverr;
      irq_pending <= next_pend && !ack.take;
      irq_vector <= next_vec;
    end
  end
endmodule : rip_core
`default_nettype wire

// ===== verif/rip_assertions.sv
// checker: port-level timing of the reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
module rip_assertions #(
  parameter int MALF_LEN = 24,
  parameter int EXT_LEN = 12
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic core_reset,
  input wire logic prescaler_clear,
  input wire logic wdog_enable,
  input wire logic irq_ack,
  input wire logic irq_pending,
  input wire logic [15:0] irq_vector,
  input wire logic [15:0] program_counter,
  input wire logic pslverr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  int oe_cnt = 0;
  int low_cnt = 0;
  // helper counts of stretch length and pin low time
  always @(posedge core_clk)
  begin
    oe_cnt <= (reset_pin_oe === 1'b1) ? oe_cnt + 1 : 0;
    low_cnt <= reset_pin_in ? 0 : low_cnt + 1;
  end
  property p_stretch_len;
    oe_cnt <= MALF_LEN;
  endproperty
  a_stretch_len: assert property (p_stretch_len) else $error("stretch too long");
  property p_oe_reset;
    reset_pin_oe |-> core_reset && !reset_pin_out;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pin pulled without reset");
  property p_pin_count;
    $rose(core_reset) && !reset_pin_oe |-> low_cnt >= EXT_LEN;
  endproperty
  a_pin_count: assert property (p_pin_count) else $error("short pin low reset");
  property p_pin_release;
    (reset_pin_in && !reset_pin_oe) [*3] |-> !core_reset;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("reset not released");
  property p_reset_state;
    disable iff (1'b0) !nrst |=> irq_vector == 16'hfffe && !irq_pending
      && program_counter == 16'hfffe;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_reset_wdog;
    disable iff (1'b0) !nrst |=> wdog_enable && prescaler_clear;
  endproperty
  a_reset_wdog: assert property (p_reset_wdog) else $error("reset timing state wrong");
  property p_prescaler;
    $fell(core_reset) |-> prescaler_clear;
  endproperty
  a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared");
  property p_pc_load;
    irq_ack && irq_pending |=> program_counter == $past(irq_vector);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc not loaded");
  c_stretch: cover property ($rose(reset_pin_oe));
  c_accept: cover property (irq_ack && irq_pending);
  c_unmapped: cover property (pslverr);
endmodule : rip_assertions
bind rip_core rip_assertions #(.MALF_LEN(MALF_LEN), .EXT_LEN(EXT_LEN)) i_rip_assertions (
  .core_clk, .nrst, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .core_reset,
  .prescaler_clear, .wdog_enable, .irq_ack, .irq_pending, .irq_vector,
  .program_counter, .pslverr);
`default_nettype wire

// ===== verif/rip_cpu_model.sv
// model: cpu sequencer that accepts pending interrupts and returns
`timescale 1ns/1ps
`default_nettype none
module rip_cpu_model (
  input wire logic core_clk,
  input wire logic irq_pending,
  input wire logic slow,
  output logic irq_ack,
  output logic irq_return,
  output logic saved_enable
);
  int wait_cnt = 0;
  initial
  begin
    irq_ack = 1'b0;
    irq_return = 1'b0;
  end
  // accept after a short or long pause, return one cycle later
  // return restores master enable from saved_enable, tied to zero
  always @(posedge core_clk)
  begin
    irq_ack <= 1'b0;
    irq_return <= irq_ack;
    if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    else if (irq_pending === 1'b1)
    begin
      irq_ack <= 1'b1;
      wait_cnt <= slow ? 9 : 4;
    end
  end
  assign saved_enable = 1'b0;
endmodule : rip_cpu_model
`default_nettype wire

// ===== verif/test_rip_core.sv
// bench: apb and event stimulus for the reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_rip_core;
  localparam int ML = 24;
  localparam logic [17:0] TRAP = 18'h06000;
  localparam logic [17:0] RAM = 18'h0a000;
  localparam logic [17:0] WD = 18'h01000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin_drv = 1'b0, slow = 1'b0;
  logic soft_irq = 1'b0, bad_opcode_irq = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, seed = 32'd78117;
  logic [31:0] prdata;
  logic [17:0] evb = 18'h0;
  logic [9:0] m;
  logic pready, pslverr, reset_pin_oe, reset_pin_out, core_reset, prescaler_clear;
  logic wdog_enable, irq_ack, irq_return, saved_enable, irq_pending;
  logic [15:0] irq_vector, program_counter;
  logic [32:0] exp_rd[$];
  logic [15:0] exp_vec[$];
  int num_errors = 0, check_count = 0, i;
  logic [7:0] sys_pre[4] = '{8'hc0, 8'hc0, 8'he0, 8'hc0};
  logic [7:0] sys_new[4] = '{8'h00, 8'h40, 8'ha0, 8'h80};
  int sys_len[4] = '{ML, ML, ML, 0};
  // pin with pull-up, pulled low by the device
  wire logic reset_pin_in = (reset_pin_oe === 1'b1) ? 1'b0 : pin_drv;
  always #5 core_clk = ~core_clk;
  rip_core #(.MALF_LEN(ML), .EXT_LEN(12)) i_rip_core (.core_clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_in, .reset_pin_out,
    .reset_pin_oe, .core_reset, .prescaler_clear, .wdog_enable, .fetch_valid(evb[13]),
    .fetch_in_sfr(evb[14]), .fetch_in_ram(evb[15]), .wdog_overflow(evb[12]), .soft_irq,
    .bad_opcode_irq, .ext_req(evb[11:0]), .uart_tx_irq(evb[16]), .converter_irq(evb[17]),
    .irq_ack, .irq_return, .saved_enable, .irq_pending, .irq_vector, .program_counter);
  rip_cpu_model i_rip_cpu_model (.core_clk, .irq_pending, .slow, .irq_ack, .irq_return,
    .saved_enable);
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // apb master: hold request until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pulse(input logic [17:0] v);
    @(posedge core_clk);
    evb <= v;
    @(posedge core_clk);
    evb <= 18'h0;
  endtask : pulse
  task automatic drain();
    int n;
    n = 0;
    while (exp_vec.size() > 0 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    check("accepts", 33'(exp_vec.size()), 33'h0);
    exp_vec.delete();
    @(posedge core_clk);
  endtask : drain
  task automatic stretch(input int len);
    int h;
    h = 0;
    repeat (60)
    begin
      @(negedge core_clk);
      h += (reset_pin_oe === 1'b1);
    end
    check("stretch", 33'(h), 33'(len));
  endtask : stretch
  // result watcher: read data and accepted vectors
  always @(negedge core_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("apb read", {pslverr, prdata}, exp_rd.pop_front());
    if (irq_ack === 1'b1 && irq_pending === 1'b1)
      check("vector", 33'(irq_vector), 33'(exp_vec.pop_front()));
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (15) @(posedge core_clk);
    pin_drv <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("wdog on", 33'(wdog_enable), 33'h1);
    rd(rip_pkg::OFF_ENABLE, 33'h0);
    rd(rip_pkg::OFF_LATCH, 33'h0);
    rd(rip_pkg::OFF_CTRL, 33'(rip_pkg::CTRL_RESET));
    rd(rip_pkg::OFF_SYSCTL, 33'(rip_pkg::SYSCTL_RESET));
    rd(8'h14, 33'h100000000);
    // maskable burst, accepted lowest level first, pin zero held back
    wr(rip_pkg::OFF_ENABLE, 32'hfff0);
    seed = lfsr(seed);
    m = seed[9:0] | 10'h001;
    slow <= seed[12];
    pulse(18'(m));
    rd(rip_pkg::OFF_LATCH, 33'({m, 4'h0}));
    wr(rip_pkg::OFF_LATCH, 32'hffffffff);
    rd(rip_pkg::OFF_LATCH, 33'({m, 4'h0}));
    for (i = 1; i < 10; i++)
      if (m[i])
      begin
        exp_vec.push_back(16'hfff6 - 16'(2 * i));
        wr(rip_pkg::OFF_ENABLE, 32'hfff1);
        drain();
      end
    rd(rip_pkg::OFF_LATCH, 33'h10);
    wr(rip_pkg::OFF_CTRL, 32'h0e);
    exp_vec.push_back(16'hfff6);
    wr(rip_pkg::OFF_ENABLE, 32'hfff1);
    drain();
    // master on but own enable off: stays pending
    pulse(18'h002);
    wr(rip_pkg::OFF_ENABLE, 32'h0001);
    rd(rip_pkg::OFF_LATCH, 33'h20);
    wr(rip_pkg::OFF_LATCH, 32'h0);
    // non-maskable sources with all enables off
    wr(rip_pkg::OFF_CTRL, 32'h00);
    wr(rip_pkg::OFF_ENABLE, 32'h0);
    exp_vec.push_back(rip_pkg::VEC_LAT2);
    pulse(TRAP);
    drain();
    exp_vec.push_back(16'hfff8);
    pulse(WD);
    drain();
    for (i = 0; i < 2; i++)
    begin
      exp_vec.push_back(rip_pkg::VEC_SOFT);
      soft_irq <= (i == 0);
      bad_opcode_irq <= (i == 1);
      drain();
    end
    soft_irq <= 1'b0;
    bad_opcode_irq <= 1'b0;
    // shared levels follow their selectors
    for (i = 0; i < 2; i++)
    begin
      wr(rip_pkg::OFF_CTRL, 32'(i) * 32'h30);
      pulse(18'h30000);
      rd(rip_pkg::OFF_LATCH, i ? 33'hc000 : 33'h0);
      if (i)
      begin
        exp_vec.push_back(16'hffe2);
        wr(rip_pkg::OFF_ENABLE, 32'h4001);
        drain();
      end
      wr(rip_pkg::OFF_LATCH, 32'h0);
      pulse(18'h00c00);
      rd(rip_pkg::OFF_LATCH, i ? 33'h0 : 33'hc000);
      wr(rip_pkg::OFF_LATCH, 32'h0);
    end
    // malfunction resets and their stretch
    wr(rip_pkg::OFF_CTRL, 32'h06);
    pulse(TRAP);
    stretch(ML);
    wr(rip_pkg::OFF_CTRL, 32'h06);
    pulse(RAM);
    stretch(0);
    wr(rip_pkg::OFF_CTRL, 32'h07);
    pulse(RAM);
    stretch(ML);
    wr(rip_pkg::OFF_CTRL, 32'h06);
    pulse(WD);
    stretch(ML);
    for (i = 0; i < 4; i++)
    begin
      wr(rip_pkg::OFF_SYSCTL, 32'(sys_pre[i]));
      wr(rip_pkg::OFF_SYSCTL, 32'(sys_new[i]));
      stretch(sys_len[i]);
    end
    // external pin: short low ignored, long low resets
    @(posedge core_clk);
    pin_drv <= 1'b0;
    repeat (5) @(posedge core_clk);
    pin_drv <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("short low", 33'(core_reset), 33'h0);
    @(posedge core_clk);
    pin_drv <= 1'b0;
    repeat (14) @(negedge core_clk);
    check("long low", 33'(core_reset), 33'h1);
    @(posedge core_clk);
    pin_drv <= 1'b1;
    repeat (4) @(negedge core_clk);
    check("released", 33'(core_reset), 33'h0);
    check("pc", 33'(program_counter), 33'(rip_pkg::VEC_RESET));
    // status: pin cause and the last accepted level 14 vector
    rd(rip_pkg::OFF_STATUS, 33'hffe20002);
    summarize();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
endmodule : test_rip_core
`default_nettype wire
